// ===== hw/spdc_top.sv
// Purpose: simd prefix decode, fault checks, fence ordering, compare flags and state save
// Assumes: the execution class of each instruction is present in the cycle after its last byte, with the record pulse
// Notes: memory side modelled as a store port with a visibility acknowledge
`timescale 1ns/1ns
`default_nettype none
module spdc_top (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic BYTE_VALID_IN,
    input wire logic [7:0] BYTE_IN,
    input wire spdc_pkg::spdc_op_t OP_CLASS_IN,
    input wire logic [31:0] ADDR_IN,
    input wire logic [31:0] SP_IN,
    input wire logic [63:0] SRC_A_IN,
    input wire logic [63:0] SRC_B_IN,
    input wire logic [31:0] MEM_DATA_IN,
    input wire logic STORE_REQ_IN,
    input wire logic STORE_ACK_IN,
    output logic INVALID_OPCODE_FAULT_OUT,
    output logic GENERAL_PROTECTION_FAULT_OUT,
    output logic RESERVED_COMBO_OUT,
    output logic [2:0] SEG_OUT,
    output logic ADDR32_OUT,
    output logic [1:0] OPCODE_SET_OUT,
    output logic STORE_ISSUE_OUT,
    output logic STORE_STALL_OUT,
    output logic NO_ALLOC_OUT,
    output logic [2:0] INTEGER_FLAGS_OUT,
    output logic [63:0] MASK_OUT,
    output logic [1:0] MASK_BITS_OUT,
    output logic [31:0] SIMD_CONTROL_STATUS_OUT,
    output logic [31:0] SP_OUT,
    output logic SAVE_ALL_OUT,
    output logic RESTORE_ALL_OUT
);
    logic rs1_reg, rst_n;
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rs1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rst_n <= rs1_reg;
        end
    end

    spdc_dec_if dec ();
    spdc_prefix_scan u_scan (
        .clk_in(CLK_IN),
        .rst_n_in(rst_n),
        .byte_valid_in(BYTE_VALID_IN),
        .byte_in(BYTE_IN),
        .dec(dec.scan)
    );

    function automatic logic dbl_lt(input logic [63:0] a, input logic [63:0] b);
        // sign-magnitude order of doubles; nan not split out here
        if (a[63] != b[63]) dbl_lt = a[63] && ((a[62:0] | b[62:0]) != 63'h0);
        else if (a[63]) dbl_lt = a[62:0] > b[62:0];
        else dbl_lt = a[62:0] < b[62:0];
    endfunction : dbl_lt

    function automatic logic is_nan(input logic [63:0] a);
        is_nan = (a[62:52] == 11'h7ff) && (a[51:0] != 52'h0);
    endfunction : is_nan

    logic ud_reg, ud_next, gp_reg, gp_next, resv_reg, resv_next, a32_reg, a32_next;
    logic [2:0] seg_reg, seg_next;
    logic [1:0] set_reg, set_next;
    logic [2:0] flags_reg, flags_next;
    logic [63:0] mask_reg, mask_next;
    logic [1:0] mbits_reg, mbits_next;
    logic [31:0] csr_reg, csr_next;
    logic [31:0] sp_reg, sp_next;
    logic save_reg, save_next, rstr_reg, rstr_next, nt_reg, nt_next;
    logic [7:0] pend_reg, pend_next;
    logic fence_reg, fence_next;
    logic issue;

    // a fence blocks later stores while any earlier store still awaits visibility
    assign STORE_STALL_OUT = fence_reg && (pend_reg != 8'h00);
    assign issue = STORE_REQ_IN && !STORE_STALL_OUT && (pend_reg != 8'hff);

    always_comb begin
        ud_next = 1'b0;
        gp_next = 1'b0;
        save_next = 1'b0;
        rstr_next = 1'b0;
        resv_next = resv_reg;
        a32_next = a32_reg;
        seg_next = seg_reg;
        set_next = set_reg;
        flags_next = flags_reg;
        mask_next = mask_reg;
        mbits_next = mbits_reg;
        csr_next = csr_reg;
        sp_next = sp_reg;
        nt_next = nt_reg;
        fence_next = fence_reg && (pend_reg != 8'h00);
        pend_next = 8'(pend_reg + 8'(issue) - 8'(STORE_ACK_IN && pend_reg != 8'h00));
        if (dec.valid) begin
            resv_next = dec.reserved_combo;
            a32_next = dec.addr32;
            seg_next = dec.seg;
            set_next = 2'(dec.sel);
            if (dec.lock_seen) begin
                ud_next = 1'b1;
            end else begin
                unique case (OP_CLASS_IN)
                    spdc_pkg::SPDC_OP_INT_MEM: gp_next = (ADDR_IN[3:0] & spdc_pkg::ALIGN_MASK) != 4'h0;
                    spdc_pkg::SPDC_OP_FENCE_S, spdc_pkg::SPDC_OP_FENCE_F: fence_next = 1'b1;
                    spdc_pkg::SPDC_OP_SCMP_O, spdc_pkg::SPDC_OP_SCMP_U: begin
                        // zf, pf, cf; unordered gives all ones
                        // plus and minus zero compare equal
                        if (is_nan(SRC_A_IN) || is_nan(SRC_B_IN)) flags_next = 3'h7;
                        else flags_next = {(SRC_A_IN == SRC_B_IN) || ((SRC_A_IN[62:0] | SRC_B_IN[62:0]) == 63'h0),
                                           1'b0, dbl_lt(SRC_A_IN, SRC_B_IN)};
                    end
                    spdc_pkg::SPDC_OP_PCMP: mask_next = (SRC_A_IN == SRC_B_IN) ? 64'hffff_ffff_ffff_ffff
                                                                               : 64'h0;
                    spdc_pkg::SPDC_OP_MSK: mbits_next = {mask_reg[63], mask_reg[31]};
                    spdc_pkg::SPDC_OP_PREF: nt_next = nt_reg;
                    spdc_pkg::SPDC_OP_NTST: nt_next = 1'b1;
                    spdc_pkg::SPDC_OP_SAVE: save_next = 1'b1;
                    spdc_pkg::SPDC_OP_RSTR: begin
                        rstr_next = 1'b1;
                        csr_next = MEM_DATA_IN;
                    end
                    spdc_pkg::SPDC_OP_CSR_LD: csr_next = MEM_DATA_IN;
                    spdc_pkg::SPDC_OP_CSR_ST: csr_next = csr_reg;
                    spdc_pkg::SPDC_OP_VMOV: sp_next = SP_IN;
                    default: nt_next = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            ud_reg <= 1'b0;
            gp_reg <= 1'b0;
            resv_reg <= 1'b0;
            a32_reg <= 1'b0;
            seg_reg <= spdc_pkg::SEG_NONE;
            set_reg <= 2'h0;
            flags_reg <= 3'h0;
            mask_reg <= 64'h0;
            mbits_reg <= 2'h0;
            csr_reg <= spdc_pkg::CSR_RESET;
            sp_reg <= spdc_pkg::RESET_VAL;
            save_reg <= 1'b0;
            rstr_reg <= 1'b0;
            nt_reg <= 1'b0;
            pend_reg <= 8'h00;
            fence_reg <= 1'b0;
        end else begin
            ud_reg <= ud_next;
            gp_reg <= gp_next;
            resv_reg <= resv_next;
            a32_reg <= a32_next;
            seg_reg <= seg_next;
            set_reg <= set_next;
            flags_reg <= flags_next;
            mask_reg <= mask_next;
            mbits_reg <= mbits_next;
            csr_reg <= csr_next;
            sp_reg <= sp_next;
            save_reg <= save_next;
            rstr_reg <= rstr_next;
            nt_reg <= nt_next;
            pend_reg <= pend_next;
            fence_reg <= fence_next;
        end
    end

    assign INVALID_OPCODE_FAULT_OUT = ud_reg;
    assign GENERAL_PROTECTION_FAULT_OUT = gp_reg;
    assign RESERVED_COMBO_OUT = resv_reg;
    assign SEG_OUT = seg_reg;
    assign ADDR32_OUT = a32_reg;
    assign OPCODE_SET_OUT = set_reg;
    assign STORE_ISSUE_OUT = issue;
    assign NO_ALLOC_OUT = nt_reg;
    assign INTEGER_FLAGS_OUT = flags_reg;
    assign MASK_OUT = mask_reg;
    assign MASK_BITS_OUT = mbits_reg;
    assign SIMD_CONTROL_STATUS_OUT = csr_reg;
    assign SP_OUT = sp_reg;
    assign SAVE_ALL_OUT = save_reg;
    assign RESTORE_ALL_OUT = rstr_reg;

    lock_fault_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && dec.lock_seen |=> INVALID_OPCODE_FAULT_OUT && !GENERAL_PROTECTION_FAULT_OUT)
        else $error("lock prefix did not fault");
    align_fault_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && OP_CLASS_IN == spdc_pkg::SPDC_OP_INT_MEM && ADDR_IN[3:0] != 4'h0
        |=> GENERAL_PROTECTION_FAULT_OUT) else $error("misaligned operand missed");
    fence_order_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        fence_reg && pend_reg != 8'h00 |-> !STORE_ISSUE_OUT) else $error("store passed fence");
    fence_stall_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && pend_reg != 8'h00 && !STORE_ACK_IN
        && (OP_CLASS_IN == spdc_pkg::SPDC_OP_FENCE_S || OP_CLASS_IN == spdc_pkg::SPDC_OP_FENCE_F)
        |=> STORE_STALL_OUT) else $error("fence did not stall");
    seg_pass_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid |=> SEG_OUT == $past(dec.seg)) else $error("segment not passed");
    cmp_flags_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && OP_CLASS_IN == spdc_pkg::SPDC_OP_SCMP_O && SRC_A_IN == SRC_B_IN
        && !is_nan(SRC_A_IN) |=> INTEGER_FLAGS_OUT[2]) else $error("equal compare flag");
    csr_load_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && OP_CLASS_IN == spdc_pkg::SPDC_OP_CSR_LD
        |=> SIMD_CONTROL_STATUS_OUT == $past(MEM_DATA_IN)) else $error("csr load lost");
    sp_keep_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && OP_CLASS_IN == spdc_pkg::SPDC_OP_VMOV |=> SP_OUT == $past(SP_IN))
        else $error("stack pointer changed");
    save_pulse_a: assert property (@(posedge CLK_IN) disable iff (!rst_n)
        dec.valid && !dec.lock_seen && OP_CLASS_IN == spdc_pkg::SPDC_OP_SAVE |=> SAVE_ALL_OUT ##1 !SAVE_ALL_OUT)
        else $error("save pulse wrong");
    cover_lock_c: cover property (@(posedge CLK_IN) disable iff (!rst_n) INVALID_OPCODE_FAULT_OUT);
    cover_fence_c: cover property (@(posedge CLK_IN) disable iff (!rst_n) STORE_STALL_OUT);
    cover_gp_c: cover property (@(posedge CLK_IN) disable iff (!rst_n) GENERAL_PROTECTION_FAULT_OUT);
endmodule : spdc_top
`default_nettype wire

// ===== hw/spdc_pkg.sv
// Purpose: shared constants and types for the simd prefix decode and checks block
// Assumes: byte-serial instruction stream, one byte per cycle
// Notes: opcode values below are this block's own instruction classes
package spdc_pkg;
    localparam logic [7:0] PFX_LOCK = 8'hf0;
    localparam logic [7:0] PFX_REPNE = 8'hf2;
    localparam logic [7:0] PFX_REP = 8'hf3;
    localparam logic [7:0] PFX_OPSZ = 8'h66;
    localparam logic [7:0] PFX_ADSZ = 8'h67;
    localparam logic [7:0] PFX_SEG_CS = 8'h2e;
    localparam logic [7:0] PFX_SEG_SS = 8'h36;
    localparam logic [7:0] PFX_SEG_DS = 8'h3e;
    localparam logic [7:0] PFX_SEG_ES = 8'h26;
    localparam logic [7:0] PFX_SEG_FS = 8'h64;
    localparam logic [7:0] PFX_SEG_GS = 8'h65;
    localparam logic [7:0] ESC_BYTE = 8'h0f;
    localparam logic [3:0] ALIGN_MASK = 4'hf;
    localparam logic [31:0] SP_STEP = 32'h0000_0010;
    localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
    localparam logic [2:0] SEG_NONE = 3'h7;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    typedef enum logic [3:0] {
        SPDC_OP_OTHER, SPDC_OP_INT_MEM, SPDC_OP_FENCE_S, SPDC_OP_FENCE_F,
        SPDC_OP_SCMP_O, SPDC_OP_SCMP_U, SPDC_OP_PCMP, SPDC_OP_MSK,
        SPDC_OP_PREF, SPDC_OP_NTST, SPDC_OP_SAVE, SPDC_OP_RSTR,
        SPDC_OP_CSR_LD, SPDC_OP_CSR_ST, SPDC_OP_VMOV
    } spdc_op_t;

    typedef enum logic [1:0] {SPDC_SEL_NONE, SPDC_SEL_F3, SPDC_SEL_F2, SPDC_SEL_66} spdc_sel_t;
endpackage : spdc_pkg

// ===== hw/spdc_dec_if.sv
// Purpose: carries decoded instruction facts between prefix scanner and checker
// Assumes: single clock
// Notes: valid is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface spdc_dec_if;
    logic valid;
    logic lock_seen;
    logic addr32;
    logic [2:0] seg;
    spdc_pkg::spdc_sel_t sel;
    logic reserved_combo;
    logic [7:0] opcode;
    modport scan (output valid, lock_seen, addr32, seg, sel, reserved_combo, opcode);
    modport use_ (input valid, lock_seen, addr32, seg, sel, reserved_combo, opcode);
endinterface : spdc_dec_if
`default_nettype wire

// ===== hw/spdc_prefix_scan.sv
// Purpose: collects prefix bytes, escape and opcode byte into one decoded record
// Assumes: bytes arrive one per cycle while byte_valid is high
// Notes: any byte after the escape, prefix or not, ends the instruction
`timescale 1ns/1ns
`default_nettype none
module spdc_prefix_scan (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    spdc_dec_if.scan dec
);
    logic lock_reg, lock_next, adsz_reg, adsz_next, esc_reg, esc_next;
    logic f2_reg, f2_next, f3_reg, f3_next, o66_reg, o66_next;
    logic [2:0] seg_reg, seg_next;
    logic valid_reg, valid_next;
    logic [7:0] op_reg, op_next;
    spdc_pkg::spdc_sel_t sel_reg, sel_next;
    logic resv_reg, resv_next;

    function automatic logic [2:0] seg_code(input logic [7:0] b);
        unique case (b)
            spdc_pkg::PFX_SEG_ES: seg_code = 3'h0;
            spdc_pkg::PFX_SEG_CS: seg_code = 3'h1;
            spdc_pkg::PFX_SEG_SS: seg_code = 3'h2;
            spdc_pkg::PFX_SEG_DS: seg_code = 3'h3;
            spdc_pkg::PFX_SEG_FS: seg_code = 3'h4;
            spdc_pkg::PFX_SEG_GS: seg_code = 3'h5;
            default: seg_code = spdc_pkg::SEG_NONE;
        endcase
    endfunction : seg_code

    always_comb begin
        lock_next = lock_reg;
        adsz_next = adsz_reg;
        esc_next = esc_reg;
        f2_next = f2_reg;
        f3_next = f3_reg;
        o66_next = o66_reg;
        seg_next = seg_reg;
        valid_next = 1'b0;
        op_next = op_reg;
        sel_next = sel_reg;
        resv_next = resv_reg;
        if (byte_valid_in) begin
            if (esc_reg) begin
                valid_next = 1'b1;
                op_next = byte_in;
                // fixed priority picks the selector; a second one present is reserved
                if (o66_reg) sel_next = spdc_pkg::SPDC_SEL_66;
                else if (f2_reg) sel_next = spdc_pkg::SPDC_SEL_F2;
                else if (f3_reg) sel_next = spdc_pkg::SPDC_SEL_F3;
                else sel_next = spdc_pkg::SPDC_SEL_NONE;
                resv_next = (32'(f2_reg) + 32'(f3_reg) + 32'(o66_reg)) > 32'd1;
                lock_next = 1'b0;
                adsz_next = 1'b0;
                esc_next = 1'b0;
                f2_next = 1'b0;
                f3_next = 1'b0;
                o66_next = 1'b0;
                seg_next = spdc_pkg::SEG_NONE;
            end else if (byte_in == spdc_pkg::PFX_LOCK) lock_next = 1'b1;
            else if (byte_in == spdc_pkg::PFX_ADSZ) adsz_next = 1'b1;
            else if (seg_code(byte_in) != spdc_pkg::SEG_NONE) seg_next = seg_code(byte_in);
            else if (byte_in == spdc_pkg::PFX_REPNE) f2_next = 1'b1;
            else if (byte_in == spdc_pkg::PFX_REP) f3_next = 1'b1;
            else if (byte_in == spdc_pkg::PFX_OPSZ) o66_next = 1'b1;
            else if (byte_in == spdc_pkg::ESC_BYTE) esc_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_reg <= 1'b0;
            adsz_reg <= 1'b0;
            esc_reg <= 1'b0;
            f2_reg <= 1'b0;
            f3_reg <= 1'b0;
            o66_reg <= 1'b0;
            seg_reg <= spdc_pkg::SEG_NONE;
            valid_reg <= 1'b0;
            op_reg <= 8'h00;
            sel_reg <= spdc_pkg::SPDC_SEL_NONE;
            resv_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            adsz_reg <= adsz_next;
            esc_reg <= esc_next;
            f2_reg <= f2_next;
            f3_reg <= f3_next;
            o66_reg <= o66_next;
            seg_reg <= seg_next;
            valid_reg <= valid_next;
            op_reg <= op_next;
            sel_reg <= sel_next;
            resv_reg <= resv_next;
        end
    end

    // lock and segment facts must be captured with the opcode, so keep copies
    logic lock_out_reg, adsz_out_reg;
    logic [2:0] seg_out_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_out_reg <= 1'b0;
            adsz_out_reg <= 1'b0;
            seg_out_reg <= spdc_pkg::SEG_NONE;
        end else if (byte_valid_in && esc_reg) begin
            lock_out_reg <= lock_reg;
            adsz_out_reg <= adsz_reg;
            seg_out_reg <= seg_reg;
        end
    end

    assign dec.valid = valid_reg;
    assign dec.lock_seen = lock_out_reg;
    assign dec.addr32 = adsz_out_reg;
    assign dec.seg = seg_out_reg;
    assign dec.sel = sel_reg;
    assign dec.reserved_combo = resv_reg;
    assign dec.opcode = op_reg;
endmodule : spdc_prefix_scan
`default_nettype wire

// ===== bench/test_simd_prefix_decode_checks.sv
// Purpose: self-checking bench for the simd prefix decode and checks block
// Assumes: class, address and operands are held from the first byte to the record pulse
// Notes: bench model keeps the pending store count, flags, mask and csr in plain variables
`timescale 1ns/1ns
`default_nettype none
module test_simd_prefix_decode_checks;
    logic CLK_IN, NRST_IN, BYTE_VALID_IN, STORE_REQ_IN, STORE_ACK_IN;
    logic [7:0] BYTE_IN;
    spdc_pkg::spdc_op_t OP_CLASS_IN;
    logic [31:0] ADDR_IN, SP_IN, MEM_DATA_IN, addr, exp_csr;
    logic [63:0] SRC_A_IN, SRC_B_IN, mask, exp_mask;
    logic inv_f, gp_f, rsv, adr32, st_issue, st_stall, no_alloc, save_all, rest_all;
    logic [2:0] seg, flags, exp_flags;
    logic [1:0] opset, mbits;
    logic [31:0] csr, sp;
    logic [7:0] pq[$];
    logic [7:0] sel_tab[4];
    logic [7:0] seg_tab[6];
    int err_count, n_checks, seed, pending;

    spdc_top u_dut (
        .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .BYTE_VALID_IN(BYTE_VALID_IN), .BYTE_IN(BYTE_IN),
        .OP_CLASS_IN(OP_CLASS_IN), .ADDR_IN(ADDR_IN), .SP_IN(SP_IN), .SRC_A_IN(SRC_A_IN),
        .SRC_B_IN(SRC_B_IN), .MEM_DATA_IN(MEM_DATA_IN), .STORE_REQ_IN(STORE_REQ_IN),
        .STORE_ACK_IN(STORE_ACK_IN), .INVALID_OPCODE_FAULT_OUT(inv_f),
        .GENERAL_PROTECTION_FAULT_OUT(gp_f), .RESERVED_COMBO_OUT(rsv), .SEG_OUT(seg),
        .ADDR32_OUT(adr32), .OPCODE_SET_OUT(opset), .STORE_ISSUE_OUT(st_issue),
        .STORE_STALL_OUT(st_stall), .NO_ALLOC_OUT(no_alloc), .INTEGER_FLAGS_OUT(flags),
        .MASK_OUT(mask), .MASK_BITS_OUT(mbits), .SIMD_CONTROL_STATUS_OUT(csr), .SP_OUT(sp),
        .SAVE_ALL_OUT(save_all), .RESTORE_ALL_OUT(rest_all)
    );

    initial begin
        CLK_IN = 1'b0;
        forever #25 CLK_IN = ~CLK_IN;
    end

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // returns at the falling edge after the outputs of the instruction have landed
    task automatic run(input spdc_pkg::spdc_op_t cls, input logic [31:0] a);
        @(negedge CLK_IN);
        OP_CLASS_IN = cls;
        ADDR_IN = a;
        BYTE_VALID_IN = 1'b1;
        foreach (pq[i]) begin
            BYTE_IN = pq[i];
            @(negedge CLK_IN);
        end
        BYTE_IN = spdc_pkg::ESC_BYTE;
        @(negedge CLK_IN);
        BYTE_IN = 8'h58;
        @(negedge CLK_IN);
        BYTE_VALID_IN = 1'b0;
        BYTE_IN = 8'h00;
        @(negedge CLK_IN);
        pq.delete();
    endtask : run

    // nan on either side reads as unordered
    function automatic logic [2:0] cmp_flags(input logic [63:0] a, input logic [63:0] b);
        if ((&a[62:52] && |a[51:0]) || (&b[62:52] && |b[51:0])) return 3'h7;
        if ($bitstoreal(a) == $bitstoreal(b)) return 3'h4;
        if ($bitstoreal(a) < $bitstoreal(b)) return 3'h1;
        return 3'h0;
    endfunction : cmp_flags

    initial begin
        #(50 * 6000);
        err_count++;
        $display("watchdog expired before the tests ended");
        give_verdict();
    end

    initial begin
        seed = 65;
        err_count = 0;
        n_checks = 0;
        pending = 0;
        NRST_IN = 1'b0;
        BYTE_VALID_IN = 1'b0;
        BYTE_IN = 8'h00;
        OP_CLASS_IN = spdc_pkg::SPDC_OP_OTHER;
        ADDR_IN = 32'h0000_0000;
        SP_IN = 32'h0000_0000;
        MEM_DATA_IN = 32'h0000_0000;
        SRC_A_IN = 64'h0000_0000_0000_0000;
        SRC_B_IN = 64'h0000_0000_0000_0000;
        STORE_REQ_IN = 1'b0;
        STORE_ACK_IN = 1'b0;
        sel_tab = '{8'h00, spdc_pkg::PFX_REP, spdc_pkg::PFX_REPNE, spdc_pkg::PFX_OPSZ};
        seg_tab = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65};
        repeat (20) @(negedge CLK_IN);
        NRST_IN = 1'b1;
        repeat (3) @(negedge CLK_IN);
        exp_csr = spdc_pkg::CSR_RESET;
        check("csr reset", exp_csr, csr);
        check("seg reset", 3'h7, seg);
        for (int i = 0; i < 4; i++) begin
            if (i > 0) pq.push_back(sel_tab[i]);
            run(spdc_pkg::SPDC_OP_OTHER, 32'h0000_0000);
            check("opcode set", i, opset);
            check("reserved single", 1'b0, rsv);
            check("seg none", 3'h7, seg);
            check("addr size none", 1'b0, adr32);
        end
        pq = '{spdc_pkg::PFX_REPNE, spdc_pkg::PFX_OPSZ};
        run(spdc_pkg::SPDC_OP_OTHER, 32'h0000_0000);
        check("reserved combo", 1'b1, rsv);
        for (int i = 0; i < 6; i++) begin
            pq = '{seg_tab[i], spdc_pkg::PFX_ADSZ};
            run(spdc_pkg::SPDC_OP_OTHER, 32'h0000_0000);
            check("seg code", i, seg);
            check("addr size", 1'b1, adr32);
            check("no fault on overrides", 1'b0, inv_f);
        end
        $display("test prefixes done");
        pq.push_back(spdc_pkg::PFX_LOCK);
        run(spdc_pkg::SPDC_OP_NTST, 32'h0000_0000);
        check("lock fault", 1'b1, inv_f);
        check("lock suppresses class", 1'b0, no_alloc);
        @(negedge CLK_IN);
        check("lock fault pulse", 1'b0, inv_f);
        run(spdc_pkg::SPDC_OP_NTST, 32'h0000_0000);
        check("no alloc set", 1'b1, no_alloc);
        check("no lock no fault", 1'b0, inv_f);
        $display("test lock done");
        for (int i = 0; i < 10; i++) begin
            addr = $random(seed);
            if (i < 2) addr[3:0] = 4'h0;
            if (i == 2) addr[3:0] = 4'h8;
            run(spdc_pkg::SPDC_OP_INT_MEM, addr);
            check("protection fault", addr[3:0] != 4'h0, gp_f);
        end
        $display("test alignment done");
        for (int i = 0; i < 9; i++) begin
            SRC_A_IN = {$random(seed), $random(seed)};
            SRC_B_IN = (i % 3 == 0) ? SRC_A_IN : {$random(seed), $random(seed)};
            if (i == 4) SRC_B_IN = 64'h7ff8_0000_0000_0001;
            if (i == 7) begin
                SRC_A_IN = 64'h0000_0000_0000_0000;
                SRC_B_IN = 64'h8000_0000_0000_0000;
            end
            run(i[0] ? spdc_pkg::SPDC_OP_SCMP_U : spdc_pkg::SPDC_OP_SCMP_O, 32'h0000_0000);
            exp_flags = cmp_flags(SRC_A_IN, SRC_B_IN);
            check("scalar flags", exp_flags, flags);
            run(spdc_pkg::SPDC_OP_PCMP, 32'h0000_0000);
            exp_mask = (SRC_A_IN == SRC_B_IN) ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_0000_0000;
            check("packed mask", exp_mask, mask);
            check("flags kept by packed", exp_flags, flags);
            run(spdc_pkg::SPDC_OP_MSK, 32'h0000_0000);
            check("mask bits", {exp_mask[63], exp_mask[31]}, mbits);
        end
        $display("test compares done");
        MEM_DATA_IN = $random(seed);
        run(spdc_pkg::SPDC_OP_CSR_LD, 32'h0000_0000);
        exp_csr = MEM_DATA_IN;
        check("csr load", exp_csr, csr);
        MEM_DATA_IN = ~MEM_DATA_IN;
        run(spdc_pkg::SPDC_OP_CSR_ST, 32'h0000_0000);
        check("csr store keeps", exp_csr, csr);
        run(spdc_pkg::SPDC_OP_SAVE, 32'h0000_0000);
        check("save pulse", 1'b1, save_all);
        check("save keeps csr", exp_csr, csr);
        @(negedge CLK_IN);
        check("save pulse end", 1'b0, save_all);
        MEM_DATA_IN = $random(seed);
        run(spdc_pkg::SPDC_OP_RSTR, 32'h0000_0000);
        exp_csr = MEM_DATA_IN;
        check("restore pulse", 1'b1, rest_all);
        check("restore csr", exp_csr, csr);
        SP_IN = $random(seed);
        addr = SP_IN;
        run(spdc_pkg::SPDC_OP_VMOV, SP_IN);
        check("stack pointer kept", addr, sp);
        SP_IN = ~SP_IN;
        run(spdc_pkg::SPDC_OP_PREF, 32'h0000_0003);
        check("prefetch sp", addr, sp);
        check("prefetch flags", exp_flags, flags);
        check("prefetch csr", exp_csr, csr);
        check("prefetch mask", exp_mask, mask);
        run(spdc_pkg::SPDC_OP_OTHER, 32'h0000_0000);
        check("no alloc cleared", 1'b0, no_alloc);
        $display("test state done");
        for (int i = 0; i < 2; i++) begin
            @(negedge CLK_IN);
            STORE_REQ_IN = 1'b1;
            #1;
            check("store before fence", 1'b1, st_issue);
            @(negedge CLK_IN);
            STORE_REQ_IN = 1'b0;
            pending = pending + 1;
            run(i == 0 ? spdc_pkg::SPDC_OP_FENCE_S : spdc_pkg::SPDC_OP_FENCE_F, 32'h0000_0000);
            STORE_REQ_IN = 1'b1;
            #1;
            check("fence stall", pending > 0, st_stall);
            check("later store held", 1'b0, st_issue);
            @(negedge CLK_IN);
            STORE_ACK_IN = 1'b1;
            @(negedge CLK_IN);
            STORE_ACK_IN = 1'b0;
            pending = pending - 1;
            #1;
            check("stall released", pending > 0, st_stall);
            check("later store issues", 1'b1, st_issue);
            STORE_REQ_IN = 1'b0;
        end
        $display("test fences done");
        give_verdict();
    end
endmodule : test_simd_prefix_decode_checks
`default_nettype wire
